/* File: dv/sfr_core_model.sv */
`timescale 1ns/100ps
module sfr_core_model (
  input  logic        clk_i,
  input  logic [15:0] rdata_i,
  output logic        rd_o,
  output logic        wr_o,
  output logic        byte_o,
  output logic        near_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o
);
  initial {rd_o, wr_o, byte_o, near_o, addr_o, wdata_o} = '0;
  task automatic acc(input logic r, w, b, n, input logic [15:0] a, d, output logic [15:0] q);
    @(posedge clk_i);
    {rd_o, wr_o, byte_o, near_o, addr_o, wdata_o} <= {r, w, b, n, a, d};
    @(posedge clk_i);
    {rd_o, wr_o, addr_o, wdata_o} <= {2'b00, ~a, ~d};
    #1 q = rdata_i;
  endtask
endmodule

/* File: dv/sfr_map_asserts.sv */
`timescale 1ns/100ps
module sfr_map_asserts (
  input logic        clk_i,
  input logic        sys_rst_i,
  input logic        rd_en_i,
  input logic        wr_en_i,
  input logic        byte_i,
  input logic [15:0] addr_i,
  input logic [15:0] rdata_o,
  input logic        rvalid_o,
  input logic        addr_err_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rv; rd_en_i |=> rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("rv late");
  property p_nrv; !rd_en_i |=> !rvalid_o; endproperty
  a_nrv: assert property (p_nrv) else $error("rv extra");
  property p_er; (rd_en_i || wr_en_i) && !byte_i && addr_i[0] |=> addr_err_o; endproperty
  a_er: assert property (p_er) else $error("err late");
  property p_ner; !addr_i[0] || byte_i |=> !addr_err_o; endproperty
  a_ner: assert property (p_ner) else $error("err extra");
  property p_bt; rd_en_i && byte_i |=> rdata_o[15:8] == 8'h00; endproperty
  a_bt: assert property (p_bt) else $error("byte hi");
  property p_gp; rd_en_i && addr_i[15:1] == 15'h0011 |=> rdata_o == 16'h0000; endproperty
  a_gp: assert property (p_gp) else $error("gap");
  property p_hi; rd_en_i && addr_i == 16'h0030 |=> rdata_o[15:8] == 8'h00; endproperty
  a_hi: assert property (p_hi) else $error("pch hi");
  property p_rs; disable iff (1'b0) sys_rst_i |=> !rvalid_o && !addr_err_o; endproperty
  a_rs: assert property (p_rs) else $error("rst");
endmodule

/* File: dv/test_sfr_space_core_irq_map.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin fails++; \
  $display("wrong value %s %h %h", nm, ex, gt); end end
module test_sfr_space_core_irq_map;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1;
  logic [47:0] flag_set_i = '0;
  logic        rd_en_i, wr_en_i, byte_i, near_i, rvalid_o, addr_err_o, irq_pending_o;
  logic [15:0] addr_i, wdata_i, rdata_o, q;
  int          fails = 0, samples_checked = 0;
  always #20 clk_i = ~clk_i;
  sfr_core_model core_u (.clk_i, .rdata_i(rdata_o), .rd_o(rd_en_i), .wr_o(wr_en_i),
    .byte_o(byte_i), .near_o(near_i), .addr_o(addr_i), .wdata_o(wdata_i));
  sfr_space_core_irq_map dut_u (.*);
  task automatic wr(input logic b, input logic [15:0] a, d);
    core_u.acc(1'b0, 1'b1, b, 1'b0, a, d, q);
  endtask
  task automatic rd(input logic b, n, input logic [15:0] a);
    core_u.acc(1'b1, 1'b0, b, n, a, 16'h0000, q);
  endtask
  task automatic finish_test();
    $display("%0d checks %0d wrong", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(1'b0, 1'b0, 16'h00a6);
    `CHK("intr_priority_1", 16'h4440, q)
    rd(1'b0, 1'b0, 16'h07fe);
    `CHK("gap", 16'h0000, q)
    $display("reset test done");
    wr(1'b0, 16'h0002, 16'ha5c3);
    wr(1'b1, 16'h0003, 16'h0011);
    rd(1'b0, 1'b1, 16'he002);
    `CHK("near", 16'h11c3, q)
    rd(1'b1, 1'b0, 16'h0003);
    `CHK("byte", 16'h0011, q)
    wr(1'b0, 16'h0005, 16'hffff);
    rd(1'b0, 1'b0, 16'h0004);
    `CHK("odd", 16'h0000, q)
    wr(1'b0, 16'h0030, 16'hffff);
    rd(1'b0, 1'b0, 16'h0030);
    `CHK("pch", 16'h00ff, q)
    wr(1'b0, 16'h0094, 16'h0001);
    @(posedge clk_i) flag_set_i <= 48'h1;
    @(posedge clk_i) flag_set_i <= '0;
    rd(1'b0, 1'b0, 16'h0084);
    `CHK("flag", 16'h0001, q)
    `CHK("irq", 1'b1, irq_pending_o)
    $display("access test done");
    finish_test();
  end
endmodule
bind sfr_space_core_irq_map sfr_map_asserts chk_u (.*);

/* File: rtl/sfr_pkg.sv */
// Summary of operation
// - special function registers occupy data addresses 0x0000 through 0x07ff, plus one register at 0x0800.
// - unused addresses inside the register region read back as zero.
// - near region 0x0000-0x1fff is reached by a 13-bit absolute address.
// - whole data space also reachable by full 16-bit direct or pointer address.
// - unimplemented bits of implemented registers read zero and ignore writes.
// - every register loads its reset value on reset; unknown ones load zero.
// - change-notice bits present depend on device variant; interrupt sources are the same in both.
// - byte writes update only the lane chosen by address bit zero.
// - word accesses must be even; misaligned raises address error, write dropped.
package sfr_pkg;

  localparam int          SFR_NUM_REGS = 46;
  localparam int          SFR_NUM_FLAGS = 48;
  localparam logic [15:0] SFR_REGION_END = 16'h07ff;
  localparam int          SFR_NEAR_BITS = 13;

  // byte offsets, in table order
  localparam logic [15:0] SFR_OFFSET [SFR_NUM_REGS] = '{
    16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e,
    16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c, 16'h001e,
    16'h0020, 16'h002e, 16'h0030, 16'h0032, 16'h0034, 16'h0036, 16'h0042, 16'h0044,
    16'h0052, 16'h0060, 16'h0062, 16'h0068, 16'h006a, 16'h0082, 16'h0084, 16'h0086,
    16'h008c, 16'h0094, 16'h0096, 16'h009c, 16'h00a4, 16'h00a6, 16'h00a8, 16'h00aa,
    16'h00ac, 16'h00ae, 16'h00b2, 16'h00c4, 16'h00e0, 16'h0800};

  // reset values; registers with unknown reset load zero
  localparam logic [15:0] SFR_RESET [SFR_NUM_REGS] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0800,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h4444, 16'h4440, 16'h4444, 16'h0044,
    16'h4044, 16'h4404, 16'h0040, 16'h0040, 16'h0000, 16'h0000};

  // implemented bits, full change-notice variant
  localparam logic [15:0] SFR_MASK [SFR_NUM_REGS] = '{
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'h00ff, 16'h00ff, 16'h00ff, 16'hffff, 16'h01ff, 16'h000c,
    16'h3fff, 16'hf8ff, 16'h69e1, 16'hf8ff, 16'h69e1, 16'hc007, 16'h3fef, 16'h20db,
    16'h0002, 16'h3fef, 16'h20db, 16'h0002, 16'h7777, 16'h7770, 16'h7777, 16'h0077,
    16'h7077, 16'h7707, 16'h0070, 16'h0070, 16'h0f7f, 16'h805e};

  // reduced change-notice variant
  localparam logic [15:0] SFR_CN1_MASK_SMALL = 16'h183f;
  localparam logic [15:0] SFR_CN2_MASK_SMALL = 16'h60e0;

  // indices of registers with special behaviour
  localparam int SFR_IDX_CHANGE_NOTICE_ENABLE_1   = 25;
  localparam int SFR_IDX_CHANGE_NOTICE_ENABLE_2   = 26;
  localparam int SFR_IDX_CHANGE_NOTICE_PULLUP_1   = 27;
  localparam int SFR_IDX_CHANGE_NOTICE_PULLUP_2   = 28;
  localparam int SFR_IDX_INTR_FLAG_0    = 30;
  localparam int SFR_IDX_INTR_FLAG_1    = 31;
  localparam int SFR_IDX_INTR_FLAG_4    = 32;
  localparam int SFR_IDX_INTR_ENABLE_0    = 33;
  localparam int SFR_IDX_INTR_ENABLE_1    = 34;
  localparam int SFR_IDX_INTR_ENABLE_4    = 35;
  localparam int SFR_IDX_INTR_PENDING_VECTOR = 44;

  localparam int SFR_VECNUM_BITS = 7;

endpackage

/* File: rtl/sfr_space_core_irq_map.sv */
`timescale 1ns/100ps
module sfr_space_core_irq_map
  import sfr_pkg::*;
#(
  parameter bit FULL_CN_VARIANT = 1'b1
)(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        rd_en_i,
  input  wire logic        wr_en_i,
  input  wire logic        byte_i,
  input  wire logic        near_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [47:0] flag_set_i,
  output logic      [15:0] rdata_o,
  output logic             rvalid_o,
  output logic             addr_err_o,
  output logic             irq_pending_o
);

  // ****************************************************************
  // address formation and decode
  // ****************************************************************
  logic [15:0] ea;
  logic [15:0] word_ea;
  logic        hit;
  logic [5:0]  hit_idx;
  logic        misaligned;
  logic [15:0] regs [SFR_NUM_REGS];
  logic [15:0] next_rdata;
  logic [47:0] flags;
  logic [47:0] enables;
  logic [15:0] pend_vec;

  function automatic logic [15:0] impl_mask(input int idx);
    logic [15:0] m;
    m = SFR_MASK[idx];
    if (!FULL_CN_VARIANT)
    begin
      if (idx == SFR_IDX_CHANGE_NOTICE_ENABLE_1 || idx == SFR_IDX_CHANGE_NOTICE_PULLUP_1)
        m = SFR_CN1_MASK_SMALL;
      if (idx == SFR_IDX_CHANGE_NOTICE_ENABLE_2 || idx == SFR_IDX_CHANGE_NOTICE_PULLUP_2)
        m = SFR_CN2_MASK_SMALL;
    end
    return m;
  endfunction

  always_comb
  begin
    if (near_i)
      ea = {3'h0, addr_i[SFR_NEAR_BITS-1:0]};
    else
      ea = addr_i;
    word_ea    = {ea[15:1], 1'b0};
    misaligned = !byte_i && ea[0];
    hit        = 1'b0;
    hit_idx    = 6'h00;
    for (int i = 0; i < SFR_NUM_REGS; i++)
    begin
      if (word_ea == SFR_OFFSET[i])
      begin
        hit     = 1'b1;
        hit_idx = 6'(i);
      end
    end
  end

  // ****************************************************************
  // interrupt flag view and lowest pending source
  // ****************************************************************
  always_comb
  begin
    flags    = {regs[SFR_IDX_INTR_FLAG_4], regs[SFR_IDX_INTR_FLAG_1], regs[SFR_IDX_INTR_FLAG_0]};
    enables  = {regs[SFR_IDX_INTR_ENABLE_4], regs[SFR_IDX_INTR_ENABLE_1], regs[SFR_IDX_INTR_ENABLE_0]};
    pend_vec = 16'h0000;
    for (int k = SFR_NUM_FLAGS - 1; k >= 0; k--)
    begin
      if (flags[k] && enables[k])
        pend_vec = {(16-SFR_VECNUM_BITS)'(0), SFR_VECNUM_BITS'(k)};
    end
  end

  // ****************************************************************
  // register storage
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < SFR_NUM_REGS; i++)
    begin
      logic [15:0] m;
      logic [15:0] v;
      m = impl_mask(i);
      v = regs[i];
      if (sys_rst_i)
        v = SFR_RESET[i] & m;
      else
      begin
        // dropped when the word address is odd
        if (wr_en_i && !misaligned && hit && hit_idx == 6'(i)
            && i != SFR_IDX_INTR_PENDING_VECTOR)
        begin
          if (!byte_i)
            v = wdata_i;
          else if (ea[0])
            v[15:8] = wdata_i[7:0];
          else
            v[7:0] = wdata_i[7:0];
        end
        // hardware set wins over a software clear in the same cycle
        if (i == SFR_IDX_INTR_FLAG_0)
          v = v | flag_set_i[15:0];
        if (i == SFR_IDX_INTR_FLAG_1)
          v = v | flag_set_i[31:16];
        if (i == SFR_IDX_INTR_FLAG_4)
          v = v | flag_set_i[47:32];
        if (i == SFR_IDX_INTR_PENDING_VECTOR)
          v = pend_vec;
        v = v & m;
      end
      regs[i] <= v;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_comb
  begin
    next_rdata = 16'h0000;
    if (hit)
    begin
      if (byte_i && ea[0])
        next_rdata = {8'h00, regs[hit_idx][15:8]};
      else if (byte_i)
        next_rdata = {8'h00, regs[hit_idx][7:0]};
      else
        next_rdata = regs[hit_idx];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_o  <= 16'h0000;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= rd_en_i;
      if (rd_en_i)
        rdata_o <= next_rdata;
    end
  end

  // ****************************************************************
  // address error and pending summary
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      addr_err_o    <= 1'b0;
      irq_pending_o <= 1'b0;
    end
    else
    begin
      addr_err_o    <= (rd_en_i || wr_en_i) && misaligned;
      irq_pending_o <= |(flags & enables);
    end
  end

endmodule
